// [verilog/seq_pkg.sv]
// Constants and types for the processor access sequencer.
// Assumes a core that holds each request until it is stepped, and an
// external memory that answers on its own free-running clock.
//
// Notes on behaviour
// - Cache off: stay synced to memory clock
// - Cache off: N access L+A, S access A
// - Branch, trap 1L+3A; swap 4L+3A(+2A)
// - Data op 1A; +2L shift; +1L+2A PC
// - Load 3L+2A, store 2L+2A, +2A PC
// - Load-multiple 3L+(n+1)A, store-multiple 2L+(n+1)A
// - Multiply (m+1)L+1A, m from operand, <=16
// - Coprocessor costs add busy-wait count b
// - Failed condition costs exactly one A
// - Cache on: run fast, sync only when needed
// - Cache hit read takes one fast cycle, two if synced
// - Cacheable miss fetches whole four-word line
// - Release core at requested word, serve follow-ons
// - Uncacheable read stays synced during sequential reads
// - Swap read always goes external
// - Writes go external until sequential writes stop
// - Internal op one fast cycle (two if synced), absorbed in fill
// - Transfer op one fast cycle, two if synced

package seq_pkg;

	// ==========================================================
	// Core operation kinds
	typedef enum logic [1:0] {
		OP_READ     = 2'h0,
		OP_WRITE    = 2'h1,
		OP_INTERNAL = 2'h2,
		OP_TRANSFER = 2'h3
	} op_kind_e;

	// ==========================================================
	// Instruction classes for the cost calculator
	typedef enum logic [3:0] {
		IC_BRANCH                    = 4'h0,
		IC_DATA_PROC                 = 4'h1,
		IC_MULTIPLY                  = 4'h2,
		IC_LOAD_SINGLE               = 4'h3,
		IC_STORE_SINGLE              = 4'h4,
		IC_LOAD_MULTIPLE             = 4'h5,
		IC_STORE_MULTIPLE            = 4'h6,
		IC_ATOMIC_SWAP_INSTRUCTION   = 4'h7,
		IC_SOFTWARE_INTERRUPT        = 4'h8,
		IC_COPROC_DATA_OPERATION     = 4'h9,
		IC_COPROC_DATA_LOAD          = 4'hA,
		IC_COPROC_DATA_STORE         = 4'hB,
		IC_COPROC_REGISTER_READ      = 4'hC,
		IC_COPROC_REGISTER_WRITE     = 4'hD
	} instr_class_e;

	// ==========================================================
	// Cycle costs, latent (L) and active (A)
	localparam int BRANCH_L      = 1;
	localparam int BRANCH_A      = 3;
	localparam int DP_A          = 1;
	localparam int DP_SHIFT_L    = 2;
	localparam int DP_PC_L       = 1;
	localparam int DP_PC_A       = 2;
	localparam int MUL_A         = 1;
	localparam int LDR_L         = 3;
	localparam int LDR_A         = 2;
	localparam int STR_L         = 2;
	localparam int STR_A         = 2;
	localparam int PC_LOAD_A     = 2;
	localparam int LDM_L         = 3;
	localparam int STM_L         = 2;
	localparam int SWAP_L        = 4;
	localparam int SWAP_A        = 3;
	localparam int SWI_L         = 1;
	localparam int SWI_A         = 3;
	localparam int CDO_L         = 2;
	localparam int CLOAD_L       = 3;
	localparam int CSTORE_L      = 4;
	localparam int CREAD_L       = 4;
	localparam int CWRITE_L      = 3;
	localparam int COP_A         = 1;
	localparam int CLOAD_EXTRA_A = 1;
	localparam int FAIL_A        = 1;
	localparam int M_MAX         = 16;

	// ==========================================================
	// Cache line geometry
	localparam int LINE_WORDS    = 4;
	localparam int WORD_LSB      = 2;
	localparam int LINE_LSB      = 4;

endpackage : seq_pkg

// [verilog/access_sequencer.sv]
// Access sequencer: fast-clock request side, memory-clock access side,
// and the per-instruction cycle cost calculator.
// Assumes requests and cache lookup results arrive on clock_in and that
// memory wait comes from a pin timed by mem_clock_in.
`timescale 1ns/10ps

module access_sequencer #(
	parameter int ADDR_W  = 26,
	parameter int BUSY_W  = 8,
	parameter int WORDS_W = 5
) (
	// Clocks and reset
	input  wire logic                  clock_in,
	input  wire logic                  mem_clock_in,
	input  wire logic                  nrst_in,
	// Core requests
	input  wire logic                  cache_on_in,
	input  wire logic                  op_valid_in,
	input  wire logic [1:0]            op_kind_in,
	input  wire logic                  op_seq_in,
	input  wire logic                  op_swap_in,
	input  wire logic                  op_cacheable_in,
	input  wire logic                  cache_hit_in,
	input  wire logic [ADDR_W-1:0]     op_addr_in,
	// Core answers
	output logic                       core_step_out,
	output logic                       mem_synced_out,
	output logic                       fill_valid_out,
	output logic [1:0]                 fill_word_out,
	// Instruction cost query
	input  wire logic                  instr_valid_in,
	input  wire logic [3:0]            instr_class_in,
	input  wire logic                  instr_cond_pass_in,
	input  wire logic                  instr_pc_in,
	input  wire logic                  instr_shift_reg_in,
	input  wire logic [WORDS_W-1:0]    instr_words_in,
	input  wire logic [31:0]           instr_mult_in,
	input  wire logic [BUSY_W-1:0]     instr_busy_in,
	output logic                       cost_valid_out,
	output logic [BUSY_W+1:0]          cost_latent_out,
	output logic [WORDS_W+1:0]         cost_active_out,
	// External memory
	input  wire logic                  mem_wait_n_in,
	output logic                       mem_req_out,
	output logic                       mem_seq_out,
	output logic                       mem_write_out,
	output logic                       mem_line_out,
	output logic                       mem_lock_out,
	output logic [ADDR_W-1:0]          mem_addr_out
);

	localparam int LAT_W = BUSY_W + 2;
	localparam int ACT_W = WORDS_W + 2;

	typedef enum logic [2:0] {
		F_READY = 3'b001,
		F_EXT   = 3'b010,
		F_FILL  = 3'b100
	} fast_state_e;

	typedef enum logic [2:0] {
		M_IDLE   = 3'b001,
		M_LATENT = 3'b010,
		M_ACTIVE = 3'b100
	} mem_state_e;

	// ==========================================================
	// Instruction cost calculator
	function automatic logic [4:0] mult_cycles(input logic [31:0] rs);
		logic [5:0] m;
		m = 6'h01;
		for (int i = 1; i < 32; i++) begin
			if (rs[i]) begin
				m = 6'((i + 1) / 2 + 1);
			end
		end
		if (m > 6'(seq_pkg::M_MAX)) begin
			m = 6'(seq_pkg::M_MAX);
		end
		return 5'(m);
	endfunction : mult_cycles

	logic [LAT_W-1:0] lat;
	logic [ACT_W-1:0] act;
	wire  [LAT_W-1:0] busy_l  = LAT_W'(instr_busy_in);
	wire  [ACT_W-1:0] words_a = ACT_W'(instr_words_in) + ACT_W'(1);
	wire  [ACT_W-1:0] pc_a    = instr_pc_in ? ACT_W'(seq_pkg::PC_LOAD_A) : '0;
	wire  [4:0]       m_cyc   = mult_cycles(instr_mult_in);

	always_comb begin
		lat = '0;
		act = '0;
		if (!instr_cond_pass_in) begin
			act = ACT_W'(seq_pkg::FAIL_A);
		end else begin
			case (instr_class_in)
			seq_pkg::IC_BRANCH: begin
				lat = LAT_W'(seq_pkg::BRANCH_L);
				act = ACT_W'(seq_pkg::BRANCH_A);
			end
			seq_pkg::IC_SOFTWARE_INTERRUPT: begin
				lat = LAT_W'(seq_pkg::SWI_L);
				act = ACT_W'(seq_pkg::SWI_A);
			end
			seq_pkg::IC_ATOMIC_SWAP_INSTRUCTION: begin
				lat = LAT_W'(seq_pkg::SWAP_L);
				act = ACT_W'(seq_pkg::SWAP_A) + pc_a;
			end
			seq_pkg::IC_DATA_PROC: begin
				lat = (instr_shift_reg_in ? LAT_W'(seq_pkg::DP_SHIFT_L) : '0)
					+ (instr_pc_in ? LAT_W'(seq_pkg::DP_PC_L) : '0);
				act = ACT_W'(seq_pkg::DP_A)
					+ (instr_pc_in ? ACT_W'(seq_pkg::DP_PC_A) : '0);
			end
			seq_pkg::IC_MULTIPLY: begin
				lat = LAT_W'(m_cyc) + LAT_W'(1);
				act = ACT_W'(seq_pkg::MUL_A);
			end
			seq_pkg::IC_LOAD_SINGLE: begin
				lat = LAT_W'(seq_pkg::LDR_L);
				act = ACT_W'(seq_pkg::LDR_A) + pc_a;
			end
			seq_pkg::IC_STORE_SINGLE: begin
				lat = LAT_W'(seq_pkg::STR_L);
				act = ACT_W'(seq_pkg::STR_A) + pc_a;
			end
			seq_pkg::IC_LOAD_MULTIPLE: begin
				lat = LAT_W'(seq_pkg::LDM_L);
				act = words_a + pc_a;
			end
			seq_pkg::IC_STORE_MULTIPLE: begin
				lat = LAT_W'(seq_pkg::STM_L);
				act = words_a;
			end
			seq_pkg::IC_COPROC_DATA_OPERATION: begin
				lat = busy_l + LAT_W'(seq_pkg::CDO_L);
				act = ACT_W'(seq_pkg::COP_A);
			end
			seq_pkg::IC_COPROC_REGISTER_READ: begin
				lat = busy_l + LAT_W'(seq_pkg::CREAD_L);
				act = ACT_W'(seq_pkg::COP_A);
			end
			seq_pkg::IC_COPROC_REGISTER_WRITE: begin
				lat = busy_l + LAT_W'(seq_pkg::CWRITE_L);
				act = ACT_W'(seq_pkg::COP_A);
			end
			seq_pkg::IC_COPROC_DATA_LOAD: begin
				lat = busy_l + LAT_W'(seq_pkg::CLOAD_L);
				act = words_a + ((instr_words_in > WORDS_W'(1))
					? ACT_W'(seq_pkg::CLOAD_EXTRA_A) : '0);
			end
			seq_pkg::IC_COPROC_DATA_STORE: begin
				lat = busy_l + LAT_W'(seq_pkg::CSTORE_L);
				act = words_a;
			end
			default: begin
				lat = '0;
				act = '0;
			end
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			cost_valid_out  <= 1'b0;
			cost_latent_out <= '0;
			cost_active_out <= '0;
		end else begin
			cost_valid_out  <= instr_valid_in;
			cost_latent_out <= lat;
			cost_active_out <= act;
		end
	end

	// ==========================================================
	// Fast side: decides cache service or memory access
	localparam int LINE_LSB_C = seq_pkg::LINE_LSB;

	fast_state_e       fstate;
	fast_state_e       next_fstate;
	logic              synced;
	logic              next_synced;
	logic              next_step;
	logic              next_issue;
	logic              cmd_tgl;
	logic [1:0]        cmd_kind;
	logic              cmd_seq;
	logic              cmd_line;
	logic              cmd_lock;
	logic [ADDR_W-1:0] cmd_addr;
	logic [1:0]        want;
	logic [3:0]        got;
	logic [ADDR_W-1:LINE_LSB_C] line_base;
	logic              ack_meta;
	logic              ack_sync;
	logic              ack_seen;
	logic              m_ack_tgl;
	logic [1:0]        m_ack_idx;

	wire       op_take    = op_valid_in && !core_step_out;
	wire       is_read    = op_kind_in == seq_pkg::OP_READ;
	wire       is_write   = op_kind_in == seq_pkg::OP_WRITE;
	wire       is_quick   = op_kind_in == seq_pkg::OP_INTERNAL
		|| op_kind_in == seq_pkg::OP_TRANSFER;
	wire       cache_serves = cache_on_in
		&& (is_quick || (is_read && cache_hit_in && !op_swap_in));
	wire       needs_line = cache_on_in && is_read && !cache_hit_in
		&& op_cacheable_in && !op_swap_in;
	wire       keep_run   = synced && op_seq_in && (is_read || is_write);
	wire       ext_seq    = cache_on_in ? keep_run : op_seq_in;
	wire [1:0] op_idx     = op_addr_in[seq_pkg::WORD_LSB +: 2];
	wire       ack_pulse  = ack_sync ^ ack_seen;
	wire [3:0] ack_hot    = ack_pulse ? (4'h1 << m_ack_idx) : 4'h0;
	wire [3:0] next_got   = got | ack_hot;
	wire       line_done  = &next_got;
	wire       fill_hit   = is_read && op_seq_in && next_got[op_idx]
		&& op_addr_in[ADDR_W-1:LINE_LSB_C] == line_base;
	wire [ADDR_W-1:0] line_addr = {op_addr_in[ADDR_W-1:LINE_LSB_C], 4'h0};

	always_comb begin
		next_fstate = fstate;
		next_synced = synced;
		next_step   = 1'b0;
		next_issue  = 1'b0;
		case (fstate)
		F_READY: begin
			if (op_take) begin
				if (synced && cache_serves) begin
					next_synced = 1'b0;
				end else if (cache_serves) begin
					next_step = 1'b1;
				end else begin
					next_issue  = 1'b1;
					next_synced = !needs_line;
					next_fstate = F_EXT;
				end
			end
		end
		F_EXT: begin
			if (ack_pulse && (!cmd_line || m_ack_idx == want)) begin
				next_step   = 1'b1;
				next_fstate = (cmd_line && !line_done) ? F_FILL : F_READY;
			end
		end
		F_FILL: begin
			if (op_take && cache_on_in && (is_quick || fill_hit)) begin
				next_step = 1'b1;
			end
			if (line_done) begin
				next_fstate = F_READY;
			end
		end
		default: begin
			next_fstate = F_READY;
		end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			fstate         <= F_READY;
			synced         <= 1'b1;
			core_step_out  <= 1'b0;
			fill_valid_out <= 1'b0;
			fill_word_out  <= 2'h0;
		end else begin
			fstate         <= next_fstate;
			synced         <= next_synced;
			core_step_out  <= next_step;
			fill_valid_out <= ack_pulse && cmd_line;
			fill_word_out  <= m_ack_idx;
		end
	end

	assign mem_synced_out = synced;

	// Command fields stay still from toggle until the answer returns
	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			cmd_tgl   <= 1'b0;
			cmd_kind  <= seq_pkg::OP_READ;
			cmd_seq   <= 1'b0;
			cmd_line  <= 1'b0;
			cmd_lock  <= 1'b0;
			cmd_addr  <= '0;
			want      <= 2'h0;
			got       <= 4'h0;
			line_base <= '0;
		end else if (next_issue) begin
			cmd_tgl   <= !cmd_tgl;
			cmd_kind  <= op_kind_in;
			cmd_seq   <= ext_seq && !needs_line;
			cmd_line  <= needs_line;
			cmd_lock  <= op_swap_in;
			cmd_addr  <= needs_line ? line_addr : op_addr_in;
			want      <= op_idx;
			got       <= 4'h0;
			line_base <= op_addr_in[ADDR_W-1:LINE_LSB_C];
		end else begin
			got       <= next_got;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			ack_meta <= 1'b0;
			ack_sync <= 1'b0;
			ack_seen <= 1'b0;
		end else begin
			ack_meta <= m_ack_tgl;
			ack_sync <= ack_meta;
			ack_seen <= ack_sync;
		end
	end

	// ==========================================================
	// Memory side: latent and active cycles on the memory clock
	mem_state_e        mstate;
	mem_state_e        next_mstate;
	logic              mrst_meta;
	logic              mrst_n;
	logic              cmd_meta;
	logic              cmd_sync;
	logic              cmd_seen;
	logic              wait_meta;
	logic              wait_ok;
	logic [ADDR_W-1:0] m_addr;
	logic [ADDR_W-1:0] next_m_addr;
	logic              m_seq;
	logic              next_m_seq;
	logic [1:0]        beat;
	logic [1:0]        next_beat;
	logic              next_ack;

	wire cmd_new  = cmd_sync ^ cmd_seen;
	wire m_quick  = cmd_kind == seq_pkg::OP_INTERNAL
		|| cmd_kind == seq_pkg::OP_TRANSFER;
	wire m_more   = cmd_line && beat != 2'(seq_pkg::LINE_WORDS - 1);

	always_comb begin
		next_mstate = mstate;
		next_m_addr = m_addr;
		next_m_seq  = m_seq;
		next_beat   = beat;
		next_ack    = 1'b0;
		case (mstate)
		M_IDLE: begin
			if (cmd_new) begin
				next_m_addr = cmd_addr;
				next_m_seq  = cmd_seq;
				next_beat   = 2'h0;
				next_mstate = (m_quick || !cmd_seq) ? M_LATENT : M_ACTIVE;
			end
		end
		M_LATENT: begin
			if (m_quick) begin
				next_ack    = 1'b1;
				next_mstate = M_IDLE;
			end else begin
				next_mstate = M_ACTIVE;
			end
		end
		M_ACTIVE: begin
			if (wait_ok) begin
				next_ack = 1'b1;
				if (m_more) begin
					next_beat   = beat + 2'h1;
					next_m_seq  = 1'b1;
					next_m_addr = m_addr + ADDR_W'(1 << seq_pkg::WORD_LSB);
				end else begin
					next_mstate = M_IDLE;
				end
			end
		end
		default: begin
			next_mstate = M_IDLE;
		end
		endcase
	end

	always_ff @(posedge mem_clock_in) begin
		mrst_meta <= nrst_in;
		mrst_n    <= mrst_meta;
	end

	always_ff @(posedge mem_clock_in) begin
		if (!mrst_n) begin
			cmd_meta  <= 1'b0;
			cmd_sync  <= 1'b0;
			cmd_seen  <= 1'b0;
			wait_meta <= 1'b0;
			wait_ok   <= 1'b0;
		end else begin
			cmd_meta  <= cmd_tgl;
			cmd_sync  <= cmd_meta;
			cmd_seen  <= cmd_sync;
			wait_meta <= mem_wait_n_in;
			wait_ok   <= wait_meta;
		end
	end

	always_ff @(posedge mem_clock_in) begin
		if (!mrst_n) begin
			mstate        <= M_IDLE;
			m_addr        <= '0;
			m_seq         <= 1'b0;
			beat          <= 2'h0;
			m_ack_tgl     <= 1'b0;
			m_ack_idx     <= 2'h0;
			mem_req_out   <= 1'b0;
			mem_seq_out   <= 1'b0;
			mem_write_out <= 1'b0;
			mem_line_out  <= 1'b0;
			mem_lock_out  <= 1'b0;
			mem_addr_out  <= '0;
		end else begin
			mstate        <= next_mstate;
			m_addr        <= next_m_addr;
			m_seq         <= next_m_seq;
			beat          <= next_beat;
			if (next_ack) begin
				m_ack_tgl <= !m_ack_tgl;
				m_ack_idx <= m_addr[seq_pkg::WORD_LSB +: 2];
			end
			mem_req_out   <= next_mstate == M_ACTIVE;
			mem_seq_out   <= next_m_seq && next_mstate == M_ACTIVE;
			mem_write_out <= cmd_kind == seq_pkg::OP_WRITE && next_mstate != M_IDLE;
			mem_line_out  <= cmd_line && next_mstate != M_IDLE;
			mem_lock_out  <= cmd_lock && next_mstate != M_IDLE;
			mem_addr_out  <= next_m_addr;
		end
	end

endmodule : access_sequencer

// [tb/access_sequencer_sva.sv]
// Checker for the access sequencer: cost, stepping and memory-link relations.
// Sees only the sequencer's ports; bound to every instance below.
`timescale 1ns/10ps

module access_sequencer_sva #(
	parameter int ADDR_W  = 26,
	parameter int BUSY_W  = 8,
	parameter int WORDS_W = 5
) (
	// Clocks and reset
	input wire logic               clock_in,
	input wire logic               mem_clock_in,
	input wire logic               nrst_in,
	// Core side
	input wire logic               cache_on_in,
	input wire logic               op_valid_in,
	input wire logic [1:0]         op_kind_in,
	input wire logic               op_swap_in,
	input wire logic               cache_hit_in,
	input wire logic               core_step_out,
	input wire logic               mem_synced_out,
	// Cost side
	input wire logic               instr_valid_in,
	input wire logic [3:0]         instr_class_in,
	input wire logic               instr_cond_pass_in,
	input wire logic               instr_pc_in,
	input wire logic [WORDS_W-1:0] instr_words_in,
	input wire logic               cost_valid_out,
	input wire logic [BUSY_W+1:0]  cost_latent_out,
	input wire logic [WORDS_W+1:0] cost_active_out,
	// Memory side
	input wire logic               mem_req_out,
	input wire logic               mem_seq_out,
	input wire logic               mem_write_out,
	input wire logic               mem_line_out,
	input wire logic               mem_lock_out,
	input wire logic [ADDR_W-1:0]  mem_addr_out
);
	// ==========================================================
	// Assertions
	cost_valid_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		cost_valid_out == $past(instr_valid_in)) else $error("cost pulse misplaced");
	cond_fail_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		instr_valid_in && !instr_cond_pass_in |=> cost_latent_out == '0 && cost_active_out == 32'h1)
		else $error("failed condition cost wrong");
	branch_cost_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		instr_valid_in && instr_cond_pass_in && instr_class_in == seq_pkg::IC_BRANCH
		|=> cost_latent_out == 32'h1 && cost_active_out == 32'h3) else $error("branch cost wrong");
	ldm_cost_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		instr_valid_in && instr_cond_pass_in && instr_class_in == seq_pkg::IC_LOAD_MULTIPLE
		|=> cost_latent_out == 32'h3 && cost_active_out == $past(instr_words_in) + 32'h1
		+ ($past(instr_pc_in) ? 32'h2 : 32'h0)) else $error("load multiple cost wrong");
	hit_read_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		op_valid_in && !core_step_out && cache_on_in && cache_hit_in && !op_swap_in
		&& op_kind_in == seq_pkg::OP_READ && !mem_synced_out |=> core_step_out)
		else $error("hit read not one cycle");
	synced_off_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		mem_synced_out && !cache_on_in |=> mem_synced_out) else $error("left memory sync");
	off_read_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		$rose(op_valid_in) && !cache_on_in && op_kind_in == seq_pkg::OP_READ
		|=> !core_step_out throughout ##[0:300] mem_req_out) else $error("read not external");
	write_ext_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		$rose(op_valid_in) && cache_on_in && op_kind_in == seq_pkg::OP_WRITE
		|-> ##[1:300] mem_req_out && mem_write_out) else $error("write not external");
	step_pulse_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		core_step_out |=> !core_step_out) else $error("step longer than a cycle");
	line_align_a: assert property (@(posedge mem_clock_in) disable iff (!nrst_in)
		mem_req_out && mem_line_out && !mem_seq_out |-> mem_addr_out[3:0] == 4'h0)
		else $error("line fetch not aligned");
	swap_lock_a: assert property (@(posedge mem_clock_in) disable iff (!nrst_in)
		mem_req_out && mem_lock_out |-> !mem_line_out) else $error("swap read used line fetch");
endmodule : access_sequencer_sva

bind access_sequencer access_sequencer_sva #(.ADDR_W(ADDR_W), .BUSY_W(BUSY_W),
	.WORDS_W(WORDS_W)) sva_u (.*);

// [tb/ext_memory_model.sv]
// External memory model: answers the first active cycle of a request after a set number
// of memory clocks, and later cycles of the same request at once. Assumes requests are timed by mem_clock_in.
`timescale 1ns/10ps

module ext_memory_model (
	// Clock and reset
	input  wire logic       mem_clock_in,
	input  wire logic       nrst_in,
	// Access and speed
	input  wire logic       mem_req_in,
	input  wire logic [2:0] slow_in,
	// Ready answer
	output logic            mem_wait_n_out
);
	logic [2:0] waited;

	always_ff @(posedge mem_clock_in) begin
		if (!nrst_in || !mem_req_in) begin
			waited <= 3'h0;
		end else if (waited != 3'h7) begin
			waited <= waited + 3'h1;
		end
	end

	// Ready shown only inside an active cycle
	assign mem_wait_n_out = mem_req_in && (waited >= slow_in);
endmodule : ext_memory_model

// [tb/cpu_clock_sync_sequencer_test.sv]
// Self-checking bench for the access sequencer: core requests, line fills,
// memory link and cost table. Assumes the memory model answers the link.
`timescale 1ns/10ps

module cpu_clock_sync_sequencer_test;
	logic        clock_in           = 1'b0;
	logic        mem_clock_in       = 1'b0;
	logic        nrst_in            = 1'b0;
	logic        cache_on_in        = 1'b0;
	logic        op_valid_in        = 1'b0;
	logic [1:0]  op_kind_in         = 2'h0;
	logic        op_seq_in          = 1'b0;
	logic        op_swap_in         = 1'b0;
	logic        op_cacheable_in    = 1'b0;
	logic        cache_hit_in       = 1'b0;
	logic [25:0] op_addr_in         = 26'h0;
	logic        instr_valid_in     = 1'b0;
	logic [3:0]  instr_class_in     = 4'h0;
	logic        instr_cond_pass_in = 1'b1;
	logic        instr_pc_in        = 1'b0;
	logic        instr_shift_reg_in = 1'b0;
	logic [4:0]  instr_words_in     = 5'h0;
	logic [31:0] instr_mult_in      = 32'h0;
	logic [7:0]  instr_busy_in      = 8'h0;
	logic [2:0]  slow               = 3'h0;
	logic        mem_wait_n_in;
	logic        core_step_out, mem_synced_out, fill_valid_out, cost_valid_out;
	logic        mem_req_out, mem_seq_out, mem_write_out, mem_line_out, mem_lock_out;
	logic [1:0]  fill_word_out;
	logic [1:0]  last_fill;
	logic [9:0]  cost_latent_out;
	logic [6:0]  cost_active_out;
	logic [25:0] mem_addr_out;
	logic        lock_seen          = 1'b0;
	int          fills              = 0;
	int          mismatches         = 0;
	int          comparisons        = 0;

	access_sequencer dut_u (.clock_in, .mem_clock_in, .nrst_in, .cache_on_in, .op_valid_in,
		.op_kind_in, .op_seq_in, .op_swap_in, .op_cacheable_in, .cache_hit_in, .op_addr_in,
		.core_step_out, .mem_synced_out, .fill_valid_out, .fill_word_out, .instr_valid_in,
		.instr_class_in, .instr_cond_pass_in, .instr_pc_in, .instr_shift_reg_in,
		.instr_words_in, .instr_mult_in, .instr_busy_in, .cost_valid_out, .cost_latent_out,
		.cost_active_out, .mem_wait_n_in, .mem_req_out, .mem_seq_out, .mem_write_out,
		.mem_line_out, .mem_lock_out, .mem_addr_out);

	ext_memory_model mem_u (.mem_clock_in, .nrst_in, .mem_req_in(mem_req_out),
		.slow_in(slow), .mem_wait_n_out(mem_wait_n_in));

	// ==========================================================
	// Clocks and monitors
	always #5 clock_in = ~clock_in;
	initial begin
		#7;
		forever #32 mem_clock_in = ~mem_clock_in;
	end
	always @(posedge clock_in) begin
		if (fill_valid_out === 1'b1) begin
			fills <= fills + 1;
			last_fill <= fill_word_out;
		end
	end
	always @(posedge mem_clock_in) begin
		if (mem_lock_out === 1'b1) begin
			lock_seen <= 1'b1;
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic print_verdict();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict

	task automatic core_op(input logic [1:0] kind, input logic [3:0] f,
		input logic [25:0] addr, output int cyc);
		cyc = 0;
		@(negedge clock_in);
		op_kind_in = kind;
		{op_seq_in, op_swap_in, op_cacheable_in, cache_hit_in} = f;
		op_addr_in = addr;
		op_valid_in = 1'b1;
		while (core_step_out !== 1'b1 && cyc < 600) begin
			@(negedge clock_in);
			cyc++;
		end
		op_valid_in = 1'b0;
		check(core_step_out, 1'b1);
	endtask : core_op

	task automatic cost_case(input logic [3:0] cls, input logic [2:0] f, input logic [4:0] n,
		input logic [31:0] mult, input int lat, input int act);
		@(negedge clock_in);
		instr_class_in = cls;
		{instr_cond_pass_in, instr_pc_in, instr_shift_reg_in} = f;
		instr_words_in = n;
		instr_mult_in = mult;
		instr_busy_in = 8'h05;
		instr_valid_in = 1'b1;
		@(negedge clock_in);
		instr_valid_in = 1'b0;
		check(cost_valid_out, 1'b1);
		check(cost_latent_out, lat);
		check(cost_active_out, act);
	endtask : cost_case

	// ==========================================================
	// Scenarios
	task automatic cost_table();
		cost_case(seq_pkg::IC_BRANCH, 3'h4, 5'h0, 32'h0, 1, 3);
		cost_case(seq_pkg::IC_SOFTWARE_INTERRUPT, 3'h4, 5'h0, 32'h0, 1, 3);
		cost_case(seq_pkg::IC_ATOMIC_SWAP_INSTRUCTION, 3'h6, 5'h0, 32'h0, 4, 5);
		cost_case(seq_pkg::IC_DATA_PROC, 3'h4, 5'h0, 32'h0, 0, 1);
		cost_case(seq_pkg::IC_DATA_PROC, 3'h7, 5'h0, 32'h0, 3, 3);
		cost_case(seq_pkg::IC_LOAD_SINGLE, 3'h6, 5'h0, 32'h0, 3, 4);
		cost_case(seq_pkg::IC_STORE_SINGLE, 3'h4, 5'h0, 32'h0, 2, 2);
		cost_case(seq_pkg::IC_LOAD_MULTIPLE, 3'h6, 5'h4, 32'h0, 3, 7);
		cost_case(seq_pkg::IC_STORE_MULTIPLE, 3'h4, 5'h10, 32'h0, 2, 17);
		cost_case(seq_pkg::IC_MULTIPLY, 3'h4, 5'h0, 32'h1, 2, 1);
		cost_case(seq_pkg::IC_MULTIPLY, 3'h4, 5'h0, 32'h7, 3, 1);
		cost_case(seq_pkg::IC_MULTIPLY, 3'h4, 5'h0, 32'h8, 4, 1);
		cost_case(seq_pkg::IC_MULTIPLY, 3'h4, 5'h0, 32'hFFFFFFFF, 17, 1);
		cost_case(seq_pkg::IC_COPROC_DATA_OPERATION, 3'h4, 5'h0, 32'h0, 7, 1);
		cost_case(seq_pkg::IC_COPROC_REGISTER_READ, 3'h4, 5'h0, 32'h0, 9, 1);
		cost_case(seq_pkg::IC_COPROC_REGISTER_WRITE, 3'h4, 5'h0, 32'h0, 8, 1);
		cost_case(seq_pkg::IC_COPROC_DATA_LOAD, 3'h4, 5'h2, 32'h0, 8, 4);
		cost_case(seq_pkg::IC_COPROC_DATA_STORE, 3'h4, 5'h2, 32'h0, 9, 3);
		cost_case(seq_pkg::IC_LOAD_MULTIPLE, 3'h2, 5'h4, 32'h0, 0, 1);
	endtask : cost_table

	task automatic off_access();
		int cyc;
		cache_on_in = 1'b0;
		core_op(seq_pkg::OP_READ, 4'h0, 26'h100, cyc);
		check(cyc > 2, 1'b1);
		core_op(seq_pkg::OP_READ, 4'h8, 26'h104, cyc);
		core_op(seq_pkg::OP_WRITE, 4'h0, 26'h108, cyc);
		core_op(seq_pkg::OP_TRANSFER, 4'h0, 26'h10C, cyc);
		check(mem_synced_out, 1'b1);
	endtask : off_access

	task automatic hit_ops();
		int cyc;
		logic [1:0] kinds [3] = '{2'h0, 2'h2, 2'h3};
		cache_on_in = 1'b1;
		core_op(seq_pkg::OP_READ, 4'h3, 26'h40, cyc);
		check(mem_synced_out, 1'b0);
		for (int k = 0; k < 3; k++) begin
			core_op(kinds[k], 4'h3, 26'h44, cyc);
			check(cyc, 1);
		end
	endtask : hit_ops

	task automatic line_fill();
		int cyc;
		fills = 0;
		core_op(seq_pkg::OP_READ, 4'h2, 26'h128, cyc);
		check(cyc > 2, 1'b1);
		core_op(seq_pkg::OP_READ, 4'hA, 26'h12C, cyc);
		for (int i = 0; i < 400 && fills < 4; i++) begin
			@(negedge clock_in);
		end
		check(fills, 4);
		check(last_fill, 2'h3);
		check(mem_synced_out, 1'b0);
	endtask : line_fill

	task automatic uncached_seq();
		int cyc;
		core_op(seq_pkg::OP_READ, 4'h0, 26'h200, cyc);
		check(mem_synced_out, 1'b1);
		core_op(seq_pkg::OP_READ, 4'h8, 26'h204, cyc);
		check(mem_synced_out, 1'b1);
		core_op(seq_pkg::OP_INTERNAL, 4'h0, 26'h208, cyc);
		check(cyc, 2);
		check(mem_synced_out, 1'b0);
	endtask : uncached_seq

	task automatic swap_write();
		int cyc;
		lock_seen = 1'b0;
		core_op(seq_pkg::OP_READ, 4'h7, 26'h300, cyc);
		check(lock_seen, 1'b1);
		core_op(seq_pkg::OP_WRITE, 4'h2, 26'h304, cyc);
		check(mem_synced_out, 1'b1);
		core_op(seq_pkg::OP_WRITE, 4'hA, 26'h308, cyc);
		check(mem_synced_out, 1'b1);
		core_op(seq_pkg::OP_READ, 4'h3, 26'h40, cyc);
		check(cyc, 2);
	endtask : swap_write

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (30) @(negedge clock_in);
		check(mem_synced_out, 1'b1);
		check(core_step_out, 1'b0);
		nrst_in = 1'b1;
		repeat (20) @(negedge clock_in);
		cost_table();
		for (int s = 0; s < 2; s++) begin
			slow = 3'(s * 5);
			off_access();
			hit_ops();
			line_fill();
			uncached_seq();
			swap_write();
		end
		print_verdict();
	end

	initial begin
		#400000;
		mismatches++;
		print_verdict();
	end
endmodule : cpu_clock_sync_sequencer_test
